// ===== verilog/rtf_defines.vh
// Register map, field positions, reset values and timing constants of the raster timing block
`ifndef RTF_DEFINES_VH
`define RTF_DEFINES_VH
// Register byte offsets
`define RTF_OFS_VTOTAL 8'h00
`define RTF_OFS_VSYNC 8'h04
`define RTF_OFS_VERTICAL_ACTIVE_SPAN 8'h08
`define RTF_OFS_HTOTAL 8'h10
`define RTF_OFS_HSYNC 8'h14
`define RTF_OFS_HACTIVE 8'h18
`define RTF_OFS_ATTRIB 8'h24
`define RTF_OFS_BASE 8'h28
`define RTF_OFS_LINES 8'h30
`define RTF_OFS_LENGTH 8'h34
`define RTF_OFS_STRIDE 8'h38
`define RTF_OFS_BRATE 8'h40
`define RTF_OFS_BMOD 8'h44
`define RTF_OFS_BMATCH 8'h48
`define RTF_OFS_BCMP 8'h4C
`define RTF_OFS_AC_TOGGLE_RATE 8'h50
`define RTF_OFS_SECPOS 8'h54
`define RTF_OFS_PIXFMT 8'h58
`define RTF_OFS_STATUS 8'h5C
// Fields of video_attributes
`define RTF_ATTR_TIMING_EN 0
`define RTF_ATTR_EOF_EN 1
`define RTF_ATTR_AC_EN 2
`define RTF_ATTR_SHIFT_EN 3
`define RTF_ATTR_BANK 4
`define RTF_ATTR_SEC_EN 5
// Start/stop pairs: start in [21:11], stop in [10:0]
`define RTF_START_HI 21
`define RTF_START_LO 11
`define RTF_STOP_HI 10
// Position fields: vertical in [26:16], horizontal in [10:0]
`define RTF_VPOS_HI 26
`define RTF_VPOS_LO 16
// Pixel format fields: depth [2:0], blink mode [7:4]
`define RTF_MODE_HI 7
`define RTF_MODE_LO 4
// Depth and blink mode encodings
`define RTF_DEPTH_OFF 3'h0
`define RTF_DEPTH_4 3'h1
`define RTF_DEPTH_8 3'h2
`define RTF_DEPTH_16 3'h4
`define RTF_DEPTH_24 3'h6
`define RTF_BLINK_OFF 4'h0
`define RTF_BLINK_AND 4'h1
`define RTF_BLINK_OR 4'h2
`define RTF_BLINK_XOR 4'h3
// Reset values and constants
`define RTF_RST_ZERO 32'h0000_0000
`define RTF_BLINK_TOP 8'hFF
`define RTF_SHIFT_PERIOD 64
`define RTF_CLK_MHZ 20
`define RTF_VIDEO_CLOCK_MAX_MHZ 132
`endif

// ===== verilog/rtf_unpack.v
// Pixel unpacker: splits 64-bit words into pixels of the selected depth
`timescale 1ns/100ps
`default_nettype none
module rtf_unpack (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_flush,
  input wire [2:0] i_depth,
  input wire [63:0] i_word,
  input wire i_word_valid,
  output wire o_word_ready,
  input wire i_take,
  output reg [23:0] o_pixel,
  output wire o_pixel_valid
);
`include "rtf_defines.vh"
  reg [63:0] shreg;
  reg [4:0] left;
  reg [4:0] count;
  reg [5:0] bpp;

  // Pixels per word and shift per pixel; illegal codes act as disabled
  always @* begin
    count = 5'd0;
    bpp = 6'd0;
    case (i_depth)
      `RTF_DEPTH_4: begin count = 5'd16; bpp = 6'd4; end
      `RTF_DEPTH_8: begin count = 5'd8; bpp = 6'd8; end
      `RTF_DEPTH_16: begin count = 5'd4; bpp = 6'd16; end
      `RTF_DEPTH_24: begin count = 5'd2; bpp = 6'd24; end
      default: begin count = 5'd0; bpp = 6'd0; end
    endcase
  end

  // Disabled depth swallows words so the fetch never locks up
  assign o_word_ready = (left == 5'd0);
  assign o_pixel_valid = (left != 5'd0);

  // Lowest pixel sits in the low bits
  always @* begin
    o_pixel = 24'h00_0000;
    if (left != 5'd0) begin
      case (i_depth)
        `RTF_DEPTH_4: o_pixel = {20'h0_0000, shreg[3:0]};
        `RTF_DEPTH_8: o_pixel = {16'h0000, shreg[7:0]};
        `RTF_DEPTH_16: o_pixel = {8'h00, shreg[15:0]};
        default: o_pixel = shreg[23:0];
      endcase
    end
  end

  // One pixel per step to the blink stage
  always @(posedge i_sys_clk) begin
    if (!i_resetn || i_flush) begin
      shreg <= 64'h0000_0000_0000_0000;
      left <= 5'd0;
    end else if (i_word_valid && left == 5'd0) begin
      shreg <= i_word;
      left <= count;
    end else if (i_take && left != 5'd0) begin
      shreg <= shreg >> bpp;
      left <= left - 5'd1;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/rtf_top.v
// Raster timing, frame fetch, pixel unpack and blink detection with an Avalon-MM register slave
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module rtf_top (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  output reg o_mem_read,
  output reg [31:0] o_mem_address,
  input wire i_mem_waitrequest,
  input wire i_mem_readdatavalid,
  input wire [31:0] i_mem_readdata,
  output reg o_hsync_n,
  output reg o_vsync_n,
  output reg o_active,
  output reg [23:0] o_pixel,
  output reg o_blink_pixel,
  output reg o_eof_irq,
  output reg o_secondary_irq
);
`include "rtf_defines.vh"
  localparam [2:0] F_IDLE = 3'b001;
  localparam [2:0] F_REQ = 3'b010;
  localparam [2:0] F_WAIT = 3'b100;

  // Software registers
  reg [10:0] total_frame_lines;
  reg [10:0] total_line_clocks;
  reg [21:0] vsync_span;
  reg [21:0] vertical_active_span;
  reg [21:0] hsync_span;
  reg [21:0] hactive_span;
  reg [7:0] video_attributes;
  reg [31:0] frame_base_address;
  reg [10:0] active_line_count;
  reg [11:0] words_per_line;
  reg [12:0] line_address_stride;
  reg [7:0] blink_period_setting;
  reg [23:0] blink_modify_mask;
  reg [23:0] blink_match_value;
  reg [23:0] blink_compare_mask;
  reg [7:0] ac_toggle_rate;
  reg [21:0] secondary_irq_position;
  reg [7:0] pixel_format_control;
  reg [31:0] next_readdata;

  // Timing state
  reg [10:0] hcnt;
  reg [10:0] vcnt;
  reg [5:0] xcnt;
  reg [7:0] ac_cnt;
  reg ac_level;
  reg [7:0] blink_cnt;
  reg blink_phase;

  // Fetch state
  reg [2:0] fstate;
  reg [31:0] line_base;
  reg [31:0] waddr;
  reg [10:0] line_left;
  reg [11:0] word_left;
  reg [31:0] pair_lo;
  reg pair_half;
  reg [63:0] word64;
  reg word_valid;

  wire word_ready;
  wire [23:0] upix;
  wire upix_valid;

  wire timing_en = video_attributes[`RTF_ATTR_TIMING_EN];
  wire [3:0] blink_mode = pixel_format_control[`RTF_MODE_HI:`RTF_MODE_LO];
  wire line_end = (hcnt == 11'd0);
  wire frame_end = timing_en && line_end && (vcnt == 11'd0);
  wire [7:0] blink_limit = `RTF_BLINK_TOP - blink_period_setting;
  wire [31:0] frame_start = {video_attributes[`RTF_ATTR_BANK], frame_base_address[30:0]};
  wire [31:0] stride_bytes = {17'h0_0000, line_address_stride, 2'b00};
  wire last_word = (word_left == 12'd0);
  wire bus_req = i_avs_read || i_avs_write;
  wire bus_done = bus_req && !o_avs_waitrequest;

  // Window test on a down counter: on from start down to just above stop
  function in_win;
    input [10:0] cnt;
    input [21:0] span;
    begin
      in_win = (cnt <= span[`RTF_START_HI:`RTF_START_LO]) && (cnt > span[`RTF_STOP_HI:0]);
    end
  endfunction

  wire hs_on = timing_en && in_win(hcnt, hsync_span);
  wire vs_on = timing_en && in_win(vcnt, vsync_span);
  wire act_now = timing_en && in_win(hcnt, hactive_span) && in_win(vcnt, vertical_active_span);
  wire panel_horizontal_shift_clock = timing_en && (xcnt == 6'd0);
  wire panel_vertical_shift_clock = hs_on;

  // Blink detection and modify stage
  wire is_blink = upix_valid && ((upix & blink_compare_mask) == blink_match_value);
  reg [23:0] mod_pix;
  always @* begin
    case (blink_mode)
      `RTF_BLINK_AND: mod_pix = upix & blink_modify_mask;
      `RTF_BLINK_OR: mod_pix = upix | blink_modify_mask;
      `RTF_BLINK_XOR: mod_pix = upix ^ blink_modify_mask;
      default: mod_pix = upix;
    endcase
  end
  wire [23:0] out_pix = (is_blink && blink_phase) ? mod_pix : upix;

  rtf_unpack u_unpack (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_flush(frame_end),
    .i_depth(pixel_format_control[2:0]),
    .i_word(word64),
    .i_word_valid(word_valid),
    .o_word_ready(word_ready),
    .i_take(act_now),
    .o_pixel(upix),
    .o_pixel_valid(upix_valid)
  );

  // Bus slave: waitrequest drops for one cycle, one cycle after a request shows
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= `RTF_RST_ZERO;
    end else begin
      o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest)
        o_avs_readdata <= next_readdata;
    end
  end

  // Read decode; unmapped addresses read zero
  always @* begin
    next_readdata = `RTF_RST_ZERO;
    if (i_avs_address == `RTF_OFS_VTOTAL) next_readdata = {21'h0, total_frame_lines};
    else if (i_avs_address == `RTF_OFS_VSYNC) next_readdata = {10'h0, vsync_span};
    else if (i_avs_address == `RTF_OFS_VERTICAL_ACTIVE_SPAN) next_readdata = {10'h0, vertical_active_span};
    else if (i_avs_address == `RTF_OFS_HTOTAL) next_readdata = {21'h0, total_line_clocks};
    else if (i_avs_address == `RTF_OFS_HSYNC) next_readdata = {10'h0, hsync_span};
    else if (i_avs_address == `RTF_OFS_HACTIVE) next_readdata = {10'h0, hactive_span};
    else if (i_avs_address == `RTF_OFS_ATTRIB) next_readdata = {24'h0, video_attributes};
    else if (i_avs_address == `RTF_OFS_BASE) next_readdata = frame_base_address;
    else if (i_avs_address == `RTF_OFS_LINES) next_readdata = {21'h0, active_line_count};
    else if (i_avs_address == `RTF_OFS_LENGTH) next_readdata = {20'h0, words_per_line};
    else if (i_avs_address == `RTF_OFS_STRIDE) next_readdata = {19'h0, line_address_stride};
    else if (i_avs_address == `RTF_OFS_BRATE) next_readdata = {24'h0, blink_period_setting};
    else if (i_avs_address == `RTF_OFS_BMOD) next_readdata = {8'h0, blink_modify_mask};
    else if (i_avs_address == `RTF_OFS_BMATCH) next_readdata = {8'h0, blink_match_value};
    else if (i_avs_address == `RTF_OFS_BCMP) next_readdata = {8'h0, blink_compare_mask};
    else if (i_avs_address == `RTF_OFS_AC_TOGGLE_RATE) next_readdata = {24'h0, ac_toggle_rate};
    else if (i_avs_address == `RTF_OFS_SECPOS)
      next_readdata = {5'h0, secondary_irq_position[21:11], 5'h0, secondary_irq_position[10:0]};
    else if (i_avs_address == `RTF_OFS_PIXFMT) next_readdata = {24'h0, pixel_format_control};
    else if (i_avs_address == `RTF_OFS_STATUS)
      next_readdata = {fstate != F_IDLE, blink_phase, ac_level, 2'h0, vcnt, 5'h0, hcnt};
  end

  // Register writes land at the edge that completes the transfer
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      total_frame_lines <= 11'h000;
      total_line_clocks <= 11'h000;
      vsync_span <= 22'h00_0000;
      vertical_active_span <= 22'h00_0000;
      hsync_span <= 22'h00_0000;
      hactive_span <= 22'h00_0000;
      video_attributes <= 8'h00;
      frame_base_address <= `RTF_RST_ZERO;
      active_line_count <= 11'h000;
      words_per_line <= 12'h000;
      line_address_stride <= 13'h0000;
      blink_period_setting <= 8'h00;
      blink_modify_mask <= 24'h00_0000;
      blink_match_value <= 24'h00_0000;
      blink_compare_mask <= 24'h00_0000;
      ac_toggle_rate <= 8'h00;
      secondary_irq_position <= 22'h00_0000;
      pixel_format_control <= 8'h00;
    end else if (i_avs_write && bus_done) begin
      if (i_avs_address == `RTF_OFS_VTOTAL) total_frame_lines <= i_avs_writedata[10:0];
      else if (i_avs_address == `RTF_OFS_VSYNC) vsync_span <= i_avs_writedata[21:0];
      else if (i_avs_address == `RTF_OFS_VERTICAL_ACTIVE_SPAN) vertical_active_span <= i_avs_writedata[21:0];
      else if (i_avs_address == `RTF_OFS_HTOTAL) total_line_clocks <= i_avs_writedata[10:0];
      else if (i_avs_address == `RTF_OFS_HSYNC) hsync_span <= i_avs_writedata[21:0];
      else if (i_avs_address == `RTF_OFS_HACTIVE) hactive_span <= i_avs_writedata[21:0];
      else if (i_avs_address == `RTF_OFS_ATTRIB) video_attributes <= i_avs_writedata[7:0];
      else if (i_avs_address == `RTF_OFS_BASE) frame_base_address <= i_avs_writedata;
      else if (i_avs_address == `RTF_OFS_LINES) active_line_count <= i_avs_writedata[10:0];
      else if (i_avs_address == `RTF_OFS_LENGTH) words_per_line <= i_avs_writedata[11:0];
      else if (i_avs_address == `RTF_OFS_STRIDE) line_address_stride <= i_avs_writedata[12:0];
      else if (i_avs_address == `RTF_OFS_BRATE) blink_period_setting <= i_avs_writedata[7:0];
      else if (i_avs_address == `RTF_OFS_BMOD) blink_modify_mask <= i_avs_writedata[23:0];
      else if (i_avs_address == `RTF_OFS_BMATCH) blink_match_value <= i_avs_writedata[23:0];
      else if (i_avs_address == `RTF_OFS_BCMP) blink_compare_mask <= i_avs_writedata[23:0];
      else if (i_avs_address == `RTF_OFS_AC_TOGGLE_RATE) ac_toggle_rate <= i_avs_writedata[7:0];
      else if (i_avs_address == `RTF_OFS_SECPOS)
        secondary_irq_position <= {i_avs_writedata[`RTF_VPOS_HI:`RTF_VPOS_LO], i_avs_writedata[10:0]};
      else if (i_avs_address == `RTF_OFS_PIXFMT) pixel_format_control <= i_avs_writedata[7:0];
    end
  end

  // Free-running counters, hcnt and vcnt down and xcnt up; hcnt and vcnt held at their totals and xcnt at zero while timing is off
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      hcnt <= 11'h000;
      vcnt <= 11'h000;
      xcnt <= 6'd0;
    end else if (!timing_en) begin
      hcnt <= total_line_clocks;
      vcnt <= total_frame_lines;
      xcnt <= 6'd0;
    end else begin
      xcnt <= xcnt + 6'd1; // Wraps every 64 clocks
      if (line_end) begin
        hcnt <= total_line_clocks;
        vcnt <= (vcnt == 11'd0) ? total_frame_lines : vcnt - 11'd1;
      end else begin
        hcnt <= hcnt - 11'd1;
      end
    end
  end

  // Frame-rate dividers for the AC level and the shared blink phase
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ac_cnt <= 8'h00;
      ac_level <= 1'b0;
      blink_cnt <= 8'h00;
      blink_phase <= 1'b0;
    end else if (frame_end) begin
      if (ac_cnt >= ac_toggle_rate) begin
        ac_cnt <= 8'h00;
        ac_level <= ~ac_level;
      end else begin
        ac_cnt <= ac_cnt + 8'h01;
      end
      // A limit of zero means the setting is at the top: no blinking
      if (blink_limit == 8'h00) begin
        blink_cnt <= 8'h00;
        blink_phase <= 1'b0;
      end else if (blink_cnt >= blink_limit - 8'h01) begin
        blink_cnt <= 8'h00;
        blink_phase <= ~blink_phase;
      end else begin
        blink_cnt <= blink_cnt + 8'h01;
      end
    end
  end

  // Registered video outputs; all events are single-cycle pulses
  // One register stage after the compares keeps paths short for a fast video clock
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_hsync_n <= 1'b1;
      o_vsync_n <= 1'b1;
      o_active <= 1'b0;
      o_pixel <= 24'h00_0000;
      o_blink_pixel <= 1'b0;
      o_eof_irq <= 1'b0;
      o_secondary_irq <= 1'b0;
    end else begin
      o_hsync_n <= ~hs_on;
      o_vsync_n <= ~vs_on;
      o_active <= act_now;
      o_blink_pixel <= act_now && is_blink && (blink_mode != `RTF_BLINK_OFF);
      o_pixel[23:18] <= act_now ? out_pix[23:18] : 6'h00;
      o_pixel[14:0] <= act_now ? out_pix[14:0] : 15'h0000;
      o_pixel[17] <= video_attributes[`RTF_ATTR_AC_EN] ? ac_level : (act_now && out_pix[17]);
      o_pixel[16] <= video_attributes[`RTF_ATTR_SHIFT_EN] ? panel_horizontal_shift_clock : (act_now && out_pix[16]);
      o_pixel[15] <= video_attributes[`RTF_ATTR_SHIFT_EN] ? panel_vertical_shift_clock : (act_now && out_pix[15]);
      // Edge-type event at the last counted position of the frame
      o_eof_irq <= frame_end && video_attributes[`RTF_ATTR_EOF_EN];
      o_secondary_irq <= timing_en && video_attributes[`RTF_ATTR_SEC_EN]
        && (vcnt == secondary_irq_position[21:11]) && (hcnt == secondary_irq_position[10:0]);
    end
  end

  // Frame fetch: restarts at a frame end that finds no read requested or in flight, with the base taken at that instant
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      fstate <= F_IDLE;
      o_mem_read <= 1'b0;
      o_mem_address <= `RTF_RST_ZERO;
      line_base <= `RTF_RST_ZERO;
      waddr <= `RTF_RST_ZERO;
      line_left <= 11'h000;
      word_left <= 12'h000;
      pair_lo <= `RTF_RST_ZERO;
      pair_half <= 1'b0;
      word64 <= 64'h0000_0000_0000_0000;
      word_valid <= 1'b0;
    end else if (frame_end && !o_mem_read && fstate != F_WAIT) begin
      // Mid-frame base writes only take hold here
      fstate <= F_REQ;
      line_base <= frame_start;
      waddr <= frame_start;
      line_left <= active_line_count;
      word_left <= words_per_line;
      pair_half <= 1'b0;
      word_valid <= 1'b0;
    end else begin
      if (word_valid && word_ready)
        word_valid <= 1'b0;
      case (fstate)
        F_REQ: begin
          // Holding word still full stalls the next read
          if (o_mem_read && !i_mem_waitrequest) begin
            o_mem_read <= 1'b0;
            fstate <= F_WAIT;
          end else if (!o_mem_read && !word_valid) begin
            o_mem_read <= 1'b1;
            o_mem_address <= waddr;
          end
        end
        F_WAIT: begin
          if (i_mem_readdatavalid) begin
            if (pair_half) begin
              word64 <= {i_mem_readdata, pair_lo};
              word_valid <= 1'b1;
              pair_half <= 1'b0;
            end else if (last_word) begin
              word64 <= {32'h0000_0000, i_mem_readdata}; // Odd word padded
              word_valid <= 1'b1;
            end else begin
              pair_lo <= i_mem_readdata;
              pair_half <= 1'b1;
            end
            if (!last_word) begin
              waddr <= waddr + 32'h0000_0004;
              word_left <= word_left - 12'd1;
              fstate <= F_REQ;
            end else if (line_left == 11'd0) begin
              fstate <= F_IDLE;
            end else begin
              line_base <= line_base + stride_bytes;
              waddr <= line_base + stride_bytes;
              word_left <= words_per_line;
              line_left <= line_left - 11'd1;
              fstate <= F_REQ;
            end
          end
        end
        default: fstate <= F_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== tb/rtf_monitor.sv
// Port-level assertions for the raster timing block
`timescale 1ns/100ps
`default_nettype none
`include "rtf_defines.vh"
module rtf_monitor (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  input wire logic o_mem_read,
  input wire logic [31:0] o_mem_address,
  input wire logic i_mem_waitrequest,
  input wire logic i_mem_readdatavalid,
  input wire logic o_hsync_n,
  input wire logic [23:0] o_pixel,
  input wire logic o_eof_irq,
  input wire logic o_secondary_irq
);
  reg shift_en;
  reg pend;
  reg seen;
  reg [6:0] gap;
  // Shadow of the shift enable, since the checker cannot see registers
  always @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      shift_en <= 1'b0;
      pend <= 1'b0;
      seen <= 1'b0;
      gap <= 7'h00;
    end else begin
      if (i_avs_write && !o_avs_waitrequest && i_avs_address == `RTF_OFS_ATTRIB)
        shift_en <= i_avs_writedata[`RTF_ATTR_SHIFT_EN];
      if (o_mem_read && !i_mem_waitrequest)
        pend <= 1'b1;
      else if (i_mem_readdatavalid)
        pend <= 1'b0;
      if ($rose(o_pixel[16])) begin
        seen <= 1'b1;
        gap <= 7'h00;
      end else if (gap != 7'h7F)
        gap <= gap + 7'h01;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_bus_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");
  a_bus_ack_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  a_bus_idle_wait: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
    else $error("waitrequest low while idle");
  a_eof_one_cycle: assert property (o_eof_irq |=> !o_eof_irq)
    else $error("frame event not a pulse");
  a_sec_one_cycle: assert property (o_secondary_irq |=> !o_secondary_irq)
    else $error("position event not a pulse");
  a_mem_req_hold: assert property (o_mem_read && i_mem_waitrequest |=> o_mem_read && $stable(o_mem_address))
    else $error("memory request dropped");
  a_mem_one_out: assert property (pend |-> !o_mem_read)
    else $error("second memory read outstanding");
  a_shift_every_64: assert property (seen && $rose(o_pixel[16]) |-> gap == 7'h3F)
    else $error("shift clock period wrong");
  a_vshift_inv_sync: assert property (shift_en && $past(shift_en, 3) |-> o_pixel[15] == !o_hsync_n)
    else $error("vertical shift not inverse of sync");
endmodule
`default_nettype wire

// ===== tb/rtf_mem_model.sv
// Behavioural frame memory read port serving the fetch engine
`timescale 1ns/100ps
`default_nettype none
module rtf_mem_model #(
  parameter logic [31:0] WORD = 32'h80C0_4081
) (
  input wire logic i_sys_clk,
  input wire logic i_slow,
  input wire logic i_read,
  output logic o_waitrequest,
  output logic o_readdatavalid,
  output logic [31:0] o_readdata
);
  logic [1:0] hold;
  initial begin
    o_waitrequest = 1'b1;
    o_readdatavalid = 1'b0;
    o_readdata = 32'h0000_0000;
    hold = 2'h0;
  end
  // Slow mode stalls each read three extra cycles; data follow one cycle after acceptance
  always @(posedge i_sys_clk) begin
    o_waitrequest <= !(i_read && o_waitrequest && hold == 2'h0);
    if (!i_read || !o_waitrequest)
      hold <= i_slow ? 2'h3 : 2'h0;
    else if (hold != 2'h0)
      hold <= hold - 2'h1;
    o_readdatavalid <= i_read && !o_waitrequest;
    // Idle data lines toggle between the last word and its complement
    o_readdata <= (i_read && !o_waitrequest) ? WORD : ~o_readdata;
  end
endmodule
`default_nettype wire

// ===== tb/rtf_tb_top.sv
// Testbench for the raster timing block
`timescale 1ns/100ps
`default_nettype none
`include "rtf_defines.vh"
`define CHK(g, w) begin total_checks++; if ((g) !== (w)) begin num_errors++; \
  $display("mismatch at %0t: got %h want %h", $time, (g), (w)); end end
module rtf_tb_top;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic slow = 1'b0;
  logic bchk = 1'b0;
  wire [31:0] o_avs_readdata, o_mem_address, i_mem_readdata;
  wire o_avs_waitrequest, o_mem_read, i_mem_waitrequest, i_mem_readdatavalid;
  wire o_hsync_n, o_vsync_n, o_active, o_blink_pixel, o_eof_irq, o_secondary_irq;
  wire [23:0] o_pixel;
  int num_errors = 0;
  int total_checks = 0;
  int cycles, fl, hl, vl, ac, sa, nfr, s_fl, s_hl, s_vl, s_ac, s_sa;
  logic [23:0] p [4];
  logic [23:0] s_p0, s_p0_prev, s_p1;
  logic ac_cur, ac_prev;
  logic [31:0] rdata;
  logic [31:0] aq [$];
  logic [7:0] ro [9] = '{`RTF_OFS_BASE, `RTF_OFS_LINES, `RTF_OFS_LENGTH, `RTF_OFS_STRIDE, `RTF_OFS_BRATE,
    `RTF_OFS_BMOD, `RTF_OFS_BMATCH, `RTF_OFS_BCMP, 8'h60};
  logic [31:0] rm [9] = '{32'hFFFFFFFF, 32'h7FF, 32'hFFF, 32'h1FFF, 32'hFF, 32'hFFFFFF, 32'hFFFFFF,
    32'hFFFFFF, 32'h0};
  logic [7:0] ca [18] = '{`RTF_OFS_HTOTAL, `RTF_OFS_VTOTAL, `RTF_OFS_HSYNC, `RTF_OFS_VSYNC, `RTF_OFS_HACTIVE,
    `RTF_OFS_VERTICAL_ACTIVE_SPAN, `RTF_OFS_SECPOS, `RTF_OFS_PIXFMT, `RTF_OFS_BCMP, `RTF_OFS_BMATCH, `RTF_OFS_BMOD,
    `RTF_OFS_BRATE, `RTF_OFS_AC_TOGGLE_RATE, `RTF_OFS_LINES, `RTF_OFS_LENGTH, `RTF_OFS_STRIDE, `RTF_OFS_BASE,
    `RTF_OFS_ATTRIB};
  logic [31:0] cd [18] = '{32'hF, 32'h9, 32'h780D, 32'h4808, 32'h6002, 32'h4001, 32'h50007, 32'h32, 32'hC0,
    32'h80, 32'hFF, 32'hFF, 32'h0, 32'h1, 32'h1, 32'h8, 32'h1000, 32'h3F};
  logic [31:0] ea [8] = '{32'h80001000, 32'h80001004, 32'h80001020, 32'h80001024, 32'h80002000,
    32'h80002004, 32'h80002020, 32'h80002024};
  logic [2:0] dp [5] = '{`RTF_DEPTH_OFF, `RTF_DEPTH_4, `RTF_DEPTH_8, `RTF_DEPTH_16, `RTF_DEPTH_24};
  logic [23:0] ex [5] = '{24'h0, 24'h1, 24'h81, 24'h4081, 24'hC04081};
  // Blink modes swept last, with a modify mask of 0x0F on the low byte 0x81
  logic [3:0] bm [3] = '{`RTF_BLINK_AND, `RTF_BLINK_OR, `RTF_BLINK_OFF};
  logic [23:0] bx [3] = '{24'h80, 24'h0E, 24'h00};
  rtf_top DUT (.i_sys_clk, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .o_avs_readdata, .o_avs_waitrequest, .o_mem_read, .o_mem_address, .i_mem_waitrequest,
    .i_mem_readdatavalid, .i_mem_readdata, .o_hsync_n, .o_vsync_n, .o_active, .o_pixel, .o_blink_pixel,
    .o_eof_irq, .o_secondary_irq);
  rtf_mem_model MEM (.i_sys_clk, .i_slow(slow), .i_read(o_mem_read), .o_waitrequest(i_mem_waitrequest),
    .o_readdatavalid(i_mem_readdatavalid), .o_readdata(i_mem_readdata));
  always #25 i_sys_clk = ~i_sys_clk;
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One bus transfer: held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= d;
    do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
    rdata = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic frames(input int n);
    int t;
    t = nfr + n;
    while (nfr < t) @(posedge i_sys_clk);
  endtask
  // Watchdog, plus per-frame statistics closed at each frame event
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("mismatch at %0t: timeout", $time);
      finish_test();
    end
    fl++;
    if (!o_hsync_n) hl++;
    if (!o_vsync_n) vl++;
    if (o_active && ac < 4) p[ac] = o_pixel;
    if (o_active) ac++;
    if (o_mem_read && !i_mem_waitrequest) aq.push_back(o_mem_address);
    if (o_secondary_irq) begin
      sa = fl;
      ac_prev = ac_cur;
      ac_cur = o_pixel[17];
    end
    if (bchk) `CHK(o_blink_pixel, ((o_pixel & 24'hC0) == 24'h80))
    if (o_eof_irq) begin
      {s_fl, s_hl, s_vl, s_ac, s_sa} = {fl, hl, vl, ac, sa};
      {s_p0_prev, s_p0, s_p1} = {s_p0, p[0], p[1]};
      {fl, hl, vl, ac, sa} = 160'h0;
      nfr++;
    end
  end
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    @(posedge i_sys_clk);
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, ro[i], 32'h0);
      `CHK(rdata, 32'h0)
      bus(1'b1, ro[i], 32'hFFFFFFFF);
      bus(1'b0, ro[i], 32'h0);
      `CHK(rdata, rm[i])
    end
    // Depth code written here is one of the legal five
    for (int i = 0; i < 18; i++) bus(1'b1, ca[i], cd[i]);
    while (aq.size() == 0) @(posedge i_sys_clk);
    bus(1'b1, `RTF_OFS_BASE, 32'h2000);
    bchk <= 1'b1;
    frames(3);
    for (int i = 0; i < 8; i++) `CHK(aq[i], ea[i])
    `CHK(s_fl, 160)
    `CHK({s_hl, s_vl, s_ac}, {32'd20, 32'd16, 32'd70})
    `CHK(s_sa, 73)
    for (int i = 0; i < 4; i++) `CHK(p[i] & 24'hFC7FFF, (32'h80C04081 >> (8 * i)) & 32'hFF)
    `CHK({p[0][7:0], p[1][7:0], p[2][7:0], p[3][7:0]}, 32'h8140C080)
    // The partner stalls during the depth sweep
    slow <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, `RTF_OFS_PIXFMT, {24'h0, `RTF_BLINK_XOR, 1'b0, dp[i]});
      frames(2);
      `CHK(p[0] & 24'hFC7FFF, ex[i])
    end
    bchk <= 1'b0;
    bus(1'b1, `RTF_OFS_BRATE, 32'hFE);
    frames(3);
    `CHK((s_p0 ^ s_p0_prev) & 24'hFF, 24'hFF)
    `CHK(s_p1 & 24'hFF, s_p0[0] ? 24'h80 : 24'h7F)
    `CHK(ac_cur ^ ac_prev, 1'b1)
    bus(1'b1, `RTF_OFS_BMOD, 32'hF);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `RTF_OFS_PIXFMT, {24'h0, bm[i], 1'b0, `RTF_DEPTH_24});
      frames(3);
      `CHK((s_p0 ^ s_p0_prev) & 24'hFF, bx[i])
    end
    finish_test();
  end
endmodule
bind rtf_top rtf_monitor MON (.i_sys_clk, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write,
  .i_avs_writedata, .o_avs_waitrequest, .o_mem_read, .o_mem_address, .i_mem_waitrequest,
  .i_mem_readdatavalid, .o_hsync_n, .o_pixel, .o_eof_irq, .o_secondary_irq);
`default_nettype wire
